// ===== cfo_pkg.sv
// Constants and types shared by the converter output path.
`default_nettype none
package cfo_pkg;
  localparam int unsigned DATA_W      = 10;  // Sample width
  localparam int unsigned LAT_CDS     = 10;  // Acquire-to-output, correlated
  localparam int unsigned LAT_DIRECT  = 9;   // Acquire-to-output, direct
  localparam int unsigned PIPE_DEPTH  = 10;  // Longest latency
  localparam int unsigned OB_FIRST    = 5;   // First cycle of black window
  localparam int unsigned OB_LAST     = 12;  // Last cycle of black window
  localparam int unsigned OB_SAMPLES  = 8;   // Samples averaged
  localparam int unsigned OB_SHIFT    = 3;   // log2 of OB_SAMPLES
  localparam int unsigned CLAMP_W     = 7;   // Clamp code width
  localparam int unsigned SH_SEL_W    = 4;   // Black S/H bandwidth field
  localparam int unsigned AMP_SEL_W   = 2;   // Amplifier bandwidth field
  localparam logic [9:0]  RST_CLAMP   = 10'h000; // Clamp reference at reset
  // Black-window tracking state
  typedef enum logic [1:0] {
    CFO_OB_IDLE = 2'b00,
    CFO_OB_WAIT = 2'b01,
    CFO_OB_SUM  = 2'b10
  } cfo_ob_t;
endpackage : cfo_pkg
`default_nettype wire

// ===== cfo_skid.sv
// Two-entry buffer with valid/ready on both sides.
`default_nettype none
module cfo_skid (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_valid,
  output logic                          o_ready,
  input  wire logic [cfo_pkg::DATA_W-1:0] i_data,
  output logic                          o_valid,
  input  wire logic                     i_ready,
  output logic [cfo_pkg::DATA_W-1:0]    o_data
);
  // Whole buffer state in one struct
  typedef struct packed {
    logic [1:0]                  cnt;  // Words held
    logic [cfo_pkg::DATA_W-1:0]  e0;   // Head entry
    logic [cfo_pkg::DATA_W-1:0]  e1;   // Second entry
  } cfo_skid_t;
  cfo_skid_t st, next_st;
  logic push, pop;

  // Full still takes a word when the head leaves in the same cycle, so a
  // one-cycle stall by the receiver loses nothing
  assign o_ready = (st.cnt != 2'd2) || i_ready;
  assign o_valid = (st.cnt != 2'd0);
  assign o_data  = st.e0;
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // Shift out at the head, append at the tail
  always_comb begin
    next_st = st;
    if (pop) begin
      next_st.e0 = st.e1;
      next_st.cnt = st.cnt - 2'd1;
    end
    if (push) begin
      if (next_st.cnt == 2'd0) begin
        next_st.e0 = i_data;
      end else begin
        next_st.e1 = i_data;
      end
      next_st.cnt = next_st.cnt + 2'd1;
    end
  end

  // Register the state
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  skid_bound_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    st.cnt <= 2'd2) else $error("buffer count above two");
endmodule : cfo_skid
`default_nettype wire

// ===== cfo_out_path.sv
// Converter output path: pipeline, black clamp, coding and tri-state.
`default_nettype none
module cfo_out_path (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_direct_mode,
  input  wire logic [cfo_pkg::DATA_W-1:0]    i_conv_sample,
  input  wire logic                          i_optical_black_pulse,
  input  wire logic                          i_pre_blanking_input,
  input  wire logic [cfo_pkg::CLAMP_W-1:0]   i_clamp_code,
  input  wire logic                          i_gray_code_test_select,
  input  wire logic                          i_top_bit_invert,
  input  wire logic                          i_lower_bits_invert,
  input  wire logic                          i_output_disable_pin,
  input  wire logic [cfo_pkg::SH_SEL_W-1:0]  i_black_sh_bandwidth_sel,
  input  wire logic [cfo_pkg::AMP_SEL_W-1:0] i_amp_bandwidth_sel,
  input  wire logic                          i_low_power_select,
  input  wire logic                          i_ready,
  output logic                               o_valid,
  output logic [cfo_pkg::DATA_W-1:0]         o_data,
  output logic [cfo_pkg::DATA_W-1:0]         o_data_oe_n,
  output logic [cfo_pkg::DATA_W-1:0]         o_clamp_ref,
  output logic [cfo_pkg::SH_SEL_W-1:0]       o_sh_time_const,
  output logic [cfo_pkg::AMP_SEL_W:0]        o_amp_setting,
  output logic                               o_amp_cfg_error,
  output logic                               o_in_ready
);
  localparam int unsigned W = cfo_pkg::DATA_W;

  // All state of the module
  typedef struct packed {
    logic [1:0]                    dis_sync;   // Disable pin synchroniser
    logic [1:0]                    obp_sync;   // Black pulse synchroniser
    logic [1:0]                    pbl_sync;   // Pre-blank synchroniser
    logic                          obp_prev;   // For edge detection
    logic [cfo_pkg::PIPE_DEPTH-1:0][W-1:0] pipe; // Converter pipeline
    cfo_pkg::cfo_ob_t              ob_state;   // Black window tracking
    logic [3:0]                    ob_cnt;     // Cycle count after pulse
    logic [W+2:0]                  ob_sum;     // Running black sum
    logic [W-1:0]                  clamp;      // Averaged clamp reference
    logic [W-1:0]                  coded;      // Word offered to buffer
    logic                          coded_vld;  // Word offered is valid
    logic [3:0]                    warm;       // Edges since reset
  } cfo_st_t;
  cfo_st_t st, next_st;

  logic          buf_ready;  // Buffer can accept
  logic [W-1:0]  buf_data;   // Buffer head
  logic [W-1:0]  tap;        // Pipeline tap for current mode
  logic [W-1:0]  word;       // Coded word before buffer
  logic          obp_rise;   // Black pulse edge

  // Direct mode taps one stage earlier than correlated mode
  assign tap = i_direct_mode ? st.pipe[cfo_pkg::LAT_DIRECT-2]
                             : st.pipe[cfo_pkg::LAT_CDS-2];
  assign obp_rise = st.obp_sync[1] && !st.obp_prev;

  // Output coding: clamp, Gray, inversion
  always_comb begin
    word = tap;
    if (st.pbl_sync[1]) begin
      // Blanking ignores both coding and polarity settings
      word = W'(i_clamp_code);
    end else begin
      if (i_gray_code_test_select) begin
        word = tap ^ (tap >> 1);
      end
      if (i_top_bit_invert) begin
        word[W-1] = ~word[W-1];
      end
      if (i_lower_bits_invert) begin
        word[W-2:0] = ~word[W-2:0];
      end
    end
  end

  // Next-state logic for the whole path
  always_comb begin
    next_st = st;
    next_st.dis_sync = {st.dis_sync[0], i_output_disable_pin};
    next_st.obp_sync = {st.obp_sync[0], i_optical_black_pulse};
    next_st.pbl_sync = {st.pbl_sync[0], i_pre_blanking_input};
    next_st.obp_prev = st.obp_sync[1];
    // Edges since reset, held at the pipeline depth for the checks
    if (st.warm != 4'(cfo_pkg::PIPE_DEPTH)) begin
      next_st.warm = st.warm + 4'd1;
    end
    // Capture on every rising edge, acquisition is stage zero
    next_st.pipe[0] = i_conv_sample;
    for (int k = 1; k < cfo_pkg::PIPE_DEPTH; k++) begin
      next_st.pipe[k] = st.pipe[k-1];
    end
    next_st.coded = word;
    next_st.coded_vld = 1'b1;
    // Black window: cycles OB_FIRST..OB_LAST after the pulse
    case (st.ob_state)
      cfo_pkg::CFO_OB_IDLE: begin
        if (obp_rise) begin
          next_st.ob_cnt = 4'd1;
          next_st.ob_sum = '0;
          next_st.ob_state = cfo_pkg::CFO_OB_WAIT;
        end
      end
      cfo_pkg::CFO_OB_WAIT: begin
        next_st.ob_cnt = st.ob_cnt + 4'd1;
        if (st.ob_cnt == 4'(cfo_pkg::OB_FIRST - 1)) begin
          next_st.ob_state = cfo_pkg::CFO_OB_SUM;
        end
      end
      cfo_pkg::CFO_OB_SUM: begin
        next_st.ob_cnt = st.ob_cnt + 4'd1;
        next_st.ob_sum = st.ob_sum + {3'h0, i_conv_sample};
        if (st.ob_cnt == 4'(cfo_pkg::OB_LAST)) begin
          // Eight samples in: divide by shifting
          next_st.clamp = W'((st.ob_sum + {3'h0, i_conv_sample})
                              >> cfo_pkg::OB_SHIFT);
          next_st.ob_state = cfo_pkg::CFO_OB_IDLE;
        end
      end
      default: begin
        next_st.ob_state = cfo_pkg::CFO_OB_IDLE;
      end
    endcase
  end

  // Single register for all state
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st <= '0;
      st.clamp <= cfo_pkg::RST_CLAMP;
    end else begin
      st <= next_st;
    end
  end

  // Two-entry buffer between coder and capturing processor; coder ignores its ready, so only the first stall cycle is absorbed
  cfo_skid u_skid (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_valid   (st.coded_vld),
    .o_ready   (buf_ready),
    .i_data    (st.coded),
    .o_valid   (o_valid),
    .i_ready   (i_ready),
    .o_data    (buf_data)
  );

  assign o_in_ready = buf_ready;
  assign o_data = buf_data;
  // Disable pin gates enables only; pipeline keeps running
  assign o_data_oe_n = {W{st.dis_sync[1]}};
  assign o_clamp_ref = st.clamp;
  // Field passed as-is: code zero widest, all ones narrowest
  assign o_sh_time_const = i_black_sh_bandwidth_sel;
  assign o_amp_setting = {i_low_power_select, i_amp_bandwidth_sel};
  // Both-low field is not a legal setting, flag it
  assign o_amp_cfg_error = (i_amp_bandwidth_sel == 2'b00);

  // Black window steps: armed one edge after the detected pulse edge,
  // four edges of waiting, eight summing edges, then back to idle
  sequence ob_armed_s;
    st.ob_state == cfo_pkg::CFO_OB_WAIT && st.ob_cnt == 4'd1;
  endsequence
  sequence ob_window_s;
    ##4 (st.ob_state == cfo_pkg::CFO_OB_SUM) [*8]
    ##1 st.ob_state == cfo_pkg::CFO_OB_IDLE;
  endsequence

  // Latency checks wait until the whole pipeline holds post-reset samples
  latency_path_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    st.warm == 4'(cfo_pkg::PIPE_DEPTH) && !i_direct_mode
    && !st.pbl_sync[1] && !i_gray_code_test_select
    && !i_top_bit_invert && !i_lower_bits_invert
    |-> next_st.coded == $past(i_conv_sample, 9))
    else $error("correlated latency wrong");
  latency_direct_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    st.warm == 4'(cfo_pkg::PIPE_DEPTH) && i_direct_mode
    && !st.pbl_sync[1] && !i_gray_code_test_select
    && !i_top_bit_invert && !i_lower_bits_invert
    |-> next_st.coded == $past(i_conv_sample, 8))
    else $error("direct latency wrong");
  // Enables follow the pin two edges late, in both directions
  disable_hiz_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    $past(i_reset_n, 2) && $past(i_reset_n)
    |-> o_data_oe_n == {W{$past(i_output_disable_pin, 2)}})
    else $error("output enables do not follow disable pin");
  window_len_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    ob_armed_s |-> ob_window_s)
    else $error("black window misplaced");
  preblank_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    st.pbl_sync[1]
    |-> next_st.coded == W'(i_clamp_code))
    else $error("pre-blank did not force clamp code");
  amp_flag_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    o_amp_cfg_error == (i_amp_bandwidth_sel == 2'b00))
    else $error("amplifier flag wrong");
endmodule : cfo_out_path
`default_nettype wire

// ===== cfo_host_model.sv
// Downstream image processor model that captures the output words.
`default_nettype none
module cfo_host_model (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_stall,
  input  wire logic                       i_seq_check,
  input  wire logic                       i_valid,
  input  wire logic [cfo_pkg::DATA_W-1:0] i_data,
  input  wire logic [cfo_pkg::DATA_W-1:0] i_data_oe_n,
  output logic                            o_ready,
  output logic [cfo_pkg::DATA_W-1:0]      o_pin,
  output logic                            o_seq_err
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [cfo_pkg::DATA_W-1:0] last_w;     // Last captured word
  logic                       have_prev;  // Ramp check has a reference
  // Released wires show the inverse of the last word, not a stale copy
  always_comb begin
    for (int i = 0; i < cfo_pkg::DATA_W; i++) begin
      o_pin[i] = i_data_oe_n[i] ? ~last_w[i] : i_data[i];
    end
  end
  // Stream is taken in every cycle without i_stall; words on released wires are ignored
  assign o_ready = ~i_stall;
  // Capture, and flag any break in an expected ramp
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      last_w    <= '0;
      have_prev <= 1'b0;
      o_seq_err <= 1'b0;
    end else if (i_valid && o_ready && !(|i_data_oe_n)) begin
      last_w    <= o_pin;
      have_prev <= i_seq_check;
      if (i_seq_check && have_prev && o_pin !== last_w + 10'h001) begin
        o_seq_err <= 1'b1;
      end
    end
  end
endmodule : cfo_host_model
`default_nettype wire

// ===== ccd_frontend_adc_output_path_test.sv
// Self-checking bench for the converter output path.
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t got %0h want %0h", $time, a, e); end end
module ccd_frontend_adc_output_path_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, dir = 0, optical_black_pulse = 0, pb = 0, gray = 0, top = 0;
  logic low = 0, dis = 0, lp = 0, stall = 0, seq = 0, rdy, vld, aerr, irdy;
  logic serr;
  // Samples arrive already taken by active-low strobes
  logic [9:0] samp = '0, dout, oe_n, clampr, pin, e;
  logic [6:0] ccode = 7'h1e;
  logic [3:0] sh = '0, shc;
  logic [1:0] amp = 2'h1;
  logic [2:0] ampc;
  int err_total = 0, cmp_count = 0, cyc = 0, n;
  always #2.5 clk = ~clk;
  cfo_out_path dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_direct_mode(dir),
    .i_conv_sample(samp), .i_optical_black_pulse(optical_black_pulse),
    .i_pre_blanking_input(pb), .i_clamp_code(ccode),
    .i_gray_code_test_select(gray), .i_top_bit_invert(top),
    .i_lower_bits_invert(low), .i_output_disable_pin(dis),
    .i_black_sh_bandwidth_sel(sh), .i_amp_bandwidth_sel(amp),
    .i_low_power_select(lp), .i_ready(rdy), .o_valid(vld), .o_data(dout),
    .o_data_oe_n(oe_n), .o_clamp_ref(clampr), .o_sh_time_const(shc),
    .o_amp_setting(ampc), .o_amp_cfg_error(aerr), .o_in_ready(irdy));
  cfo_host_model host_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_stall(stall),
    .i_seq_check(seq), .i_valid(vld), .i_data(dout), .i_data_oe_n(oe_n),
    .o_ready(rdy), .o_pin(pin), .o_seq_err(serr));
  // Print the counts and the verdict, then stop
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // One marker sample, then count cycles until its coded word heads out
  task automatic probe(input logic [9:0] v, input logic [9:0] x,
                       output int k);
    @(posedge clk) samp <= v;
    @(posedge clk) samp <= '0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!(vld === 1'b1 && dout === x) && k < 40);
  endtask : probe
  // Hang guard: the whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    `CHK(oe_n, 10'h000)
    `CHK(dout, 10'h000)
    rst_n <= 1;
    repeat (12) @(posedge clk);
    probe(10'h2a5, 10'h2a5, n);
    `CHK(n, cfo_pkg::LAT_CDS + 1)
    dir <= 1;
    repeat (12) @(posedge clk);
    probe(10'h2a5, 10'h2a5, n);
    `CHK(n, cfo_pkg::LAT_DIRECT + 1)
    dir <= 0;
    // Every polarity pair, plain and Gray coded
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) {gray, top, low} <= k[2:0];
      e = k[2] ? 10'h2c6 ^ 10'h163 : 10'h2c6;
      e = e ^ {k[1], {9{k[0]}}};
      repeat (12) @(posedge clk);
      probe(10'h2c6, e, n);
      `CHK(n, cfo_pkg::LAT_CDS + 1)
    end
    @(posedge clk) {gray, top, low} <= 3'h0;
    // Two black windows, each setting the averaged level
    for (int k = 0; k < 2; k++) begin
      e = k ? 10'h00e : 10'h03c;
      @(posedge clk) samp <= e;
      optical_black_pulse <= 1;
      repeat (24) @(posedge clk);
      samp <= '0;
      optical_black_pulse <= 0;
      @(negedge clk) `CHK(clampr, e)
    end
    // Blanking forces the programmed code; polarity bits do not apply
    @(posedge clk) {pb, top, low, ccode} <= {3'h7, 7'h2b};
    probe(10'h000, 10'h02b, n);
    `CHK(n < 40, 1'b1)
    @(posedge clk) {pb, top, low} <= 3'h0;
    dis <= 1;
    repeat (3) @(posedge clk);
    @(negedge clk) `CHK(oe_n, 10'h3ff)
    @(posedge clk) dis <= 0;
    repeat (3) @(posedge clk);
    @(negedge clk) `CHK(oe_n, 10'h000)
    probe(10'h1c3, 10'h1c3, n);
    `CHK(n, cfo_pkg::LAT_CDS + 1)
    // Ramp with a one-cycle stall: no word may be lost
    for (int i = 0; i < 60; i++) begin
      @(posedge clk) samp <= samp + 10'h001;
      seq <= (i > 14 && i < 50);
      stall <= (i == 25);
    end
    @(negedge clk) `CHK(serr, 1'b0)
    @(posedge clk) stall <= 1;
    repeat (3) @(posedge clk);
    @(negedge clk) `CHK(irdy, 1'b0)
    `CHK(vld, 1'b1)
    @(posedge clk) stall <= 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) sh <= i[3:0];
      @(negedge clk) `CHK(shc, i[3:0])
    end
    // Only legal amplifier codes: the both-low field is never programmed
    for (int i = 0; i < 8; i++) begin
      if (i[1:0] != 2'h0) begin
        @(posedge clk) {lp, amp} <= i[2:0];
        @(negedge clk) `CHK(ampc, i[2:0])
        `CHK(aerr, 1'b0)
      end
    end
    report_and_stop();
  end
endmodule : ccd_frontend_adc_output_path_test
`default_nettype wire
